// ### csg_cfg.svh
`ifndef CSG_CFG_SVH
`define CSG_CFG_SVH

// ----------------------------------------------------------------
// Strap encodings
// ----------------------------------------------------------------
`define CSG_SRC_PRIMARY   2'h0
`define CSG_SRC_SECONDARY 2'h1
`define CSG_SRC_XTAL_AC   2'h2
`define CSG_SRC_XTAL_DC   2'h3

`define CSG_DRV_LVPECL    2'h0
`define CSG_DRV_LVDS      2'h1
`define CSG_DRV_HCSL      2'h2
`define CSG_DRV_HIZ       2'h3

// ----------------------------------------------------------------
// Register map (byte addresses) and fields
// ----------------------------------------------------------------
`define CSG_ADDR_W        4
`define CSG_OFS_CTRL      4'h0
`define CSG_OFS_STATUS    4'h4
`define CSG_CTRL_ALLOW    0
`define CSG_CTRL_RESET    1'h1
`define CSG_ST_SEL_LO     0
`define CSG_ST_OSC        2
`define CSG_ST_REF        3
`define CSG_ST_BANKA_LO   4
`define CSG_ST_BANKB_LO   6
`define CSG_ST_CLK        8

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define CSG_RESP_OKAY     2'h0
`define CSG_RESP_SLVERR   2'h2

`endif

// ### csg_pkg.sv
`default_nettype none

package csg_pkg;

  // ----------------------------------------------------------------
  // Decoded driver type of an output bank
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CSG_LVPECL,
    CSG_LVDS,
    CSG_HCSL,
    CSG_HIZ
  } csg_drv_type;

  // ----------------------------------------------------------------
  // Whole state of the top module
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        aw_got;     // Write address held
    logic [3:0]  aw_addr;    // Held write address
    logic        w_got;      // Write data held
    logic        w_bit;      // Held control bit
    logic        w_lane0;    // Held strobe of byte lane 0
    logic        bvalid;     // Write answer pending
    logic [1:0]  bresp;      // Write answer code
    logic        rvalid;     // Read answer pending
    logic [31:0] rdata;      // Read answer data
    logic [1:0]  rresp;      // Read answer code
    logic        ref_allow;  // Software permission for ref output
    logic        sel_now;    // Sampled selected clock
    logic        sel_prev;   // Previous sample
    logic        en_s1;      // Enable, first falling-edge stage
    logic        ref_gate;   // Enable, applied gate
    logic        ref_out;    // Gated reference copy
    logic        bank_a_clk; // Bank A clock
    logic        bank_b_clk; // Bank B clock
    logic        osc_run;    // Oscillator powered
    logic        xdrv;       // Crystal drive level
  } csg_state_type;

endpackage : csg_pkg

`default_nettype wire

// ### csg_top.sv
`timescale 1ns/10ps
`default_nettype none

`include "csg_cfg.svh"

module csg_top
  import csg_pkg::*;
(
  input  wire logic        clock,                 // System clock, 20 MHz
  input  wire logic        rstn,                  // Synchronous reset, active low
  input  wire logic        primary_clock_input,   // First input pair, sampled
  input  wire logic        secondary_clock_input, // Second input pair, sampled
  input  wire logic        crystal_input_pin,     // Crystal or bypass clock pin
  input  wire logic [1:0]  input_source_select,   // Source strap
  input  wire logic [1:0]  bank_a_driver_type,    // Bank A type strap
  input  wire logic [1:0]  bank_b_driver_type,    // Bank B type strap
  input  wire logic        ref_enable_pin,        // Reference enable, high on
  output logic             crystal_drive_pin,     // Oscillator drive
  output logic             osc_power_down,        // High while oscillator off
  output logic             bank_a_clock,          // Bank A clock
  output logic             bank_a_oe,             // Bank A driving
  output csg_drv_type      bank_a_mode,           // Bank A driver type
  output logic             bank_b_clock,          // Bank B clock
  output logic             bank_b_oe,             // Bank B driving
  output csg_drv_type      bank_b_mode,           // Bank B driver type
  output logic             ref_clock_out,         // Reference output level
  output logic             ref_clock_oe,          // Reference driving
  input  wire logic [3:0]  s_axi_awaddr,          // Write address
  input  wire logic        s_axi_awvalid,         // Write address valid
  output logic             s_axi_awready,         // Write address ready
  input  wire logic [31:0] s_axi_wdata,           // Write data
  input  wire logic [3:0]  s_axi_wstrb,           // Write strobes
  input  wire logic        s_axi_wvalid,          // Write data valid
  output logic             s_axi_wready,          // Write data ready
  output logic [1:0]       s_axi_bresp,           // Write response
  output logic             s_axi_bvalid,          // Write response valid
  input  wire logic        s_axi_bready,          // Write response ready
  input  wire logic [3:0]  s_axi_araddr,          // Read address
  input  wire logic        s_axi_arvalid,         // Read address valid
  output logic             s_axi_arready,         // Read address ready
  output logic [31:0]      s_axi_rdata,           // Read data
  output logic [1:0]       s_axi_rresp,           // Read response
  output logic             s_axi_rvalid,          // Read data valid
  input  wire logic        s_axi_rready           // Read data ready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  csg_state_type st_reg;   // Registered state
  csg_state_type st_next;  // Next state

  // ----------------------------------------------------------------
  // Strap decode
  // ----------------------------------------------------------------
  logic        sel_raw;   // Selected input before sampling
  logic        osc_on;    // Oscillator wanted
  logic        fall;      // Falling edge of sampled selected clock
  logic        ref_req;   // Combined enable request
  logic [31:0] status;    // Status word
  csg_drv_type mode_a;    // Decoded bank A type
  csg_drv_type mode_b;    // Decoded bank B type

  // Map a strap to a driver type
  function automatic csg_drv_type drv_decode(input logic [1:0] strap);
    csg_drv_type res;
    case (strap)
      `CSG_DRV_LVPECL: res = CSG_LVPECL;
      `CSG_DRV_LVDS:   res = CSG_LVDS;
      `CSG_DRV_HCSL:   res = CSG_HCSL;
      default:         res = CSG_HIZ;
    endcase
    return res;
  endfunction : drv_decode

  // Source mux; straps are used live, so a change mid-run may glitch
  always_comb
  begin
    case (input_source_select)
      `CSG_SRC_PRIMARY:   sel_raw = primary_clock_input;
      `CSG_SRC_SECONDARY: sel_raw = secondary_clock_input;
      `CSG_SRC_XTAL_AC:   sel_raw = crystal_input_pin;
      default:            sel_raw = crystal_input_pin;
    endcase
    // Only the AC crystal path needs the oscillator; pairs keep it off
    osc_on = (input_source_select == `CSG_SRC_XTAL_AC);
    mode_a = drv_decode(bank_a_driver_type);
    mode_b = drv_decode(bank_b_driver_type);
    fall   = st_reg.sel_prev & ~st_reg.sel_now;
    ref_req = ref_enable_pin & st_reg.ref_allow;
  end

  // Status word seen by software
  always_comb
  begin
    status = 32'h0;
    status[`CSG_ST_SEL_LO +: 2]   = input_source_select;
    status[`CSG_ST_OSC]           = st_reg.osc_run;
    status[`CSG_ST_REF]           = st_reg.ref_gate;
    status[`CSG_ST_BANKA_LO +: 2] = bank_a_driver_type;
    status[`CSG_ST_BANKB_LO +: 2] = bank_b_driver_type;
    status[`CSG_ST_CLK]           = st_reg.sel_now;
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;

    // Clock path: static levels pass straight through the sampler
    st_next.sel_now  = sel_raw;
    st_next.sel_prev = st_reg.sel_now;
    st_next.osc_run  = osc_on;
    // Oscillator drive inverts the crystal pin only while powered
    st_next.xdrv     = osc_on & ~crystal_input_pin;

    // Banks carry the clock only when not high impedance
    st_next.bank_a_clk = (mode_a != CSG_HIZ) & st_reg.sel_now;
    st_next.bank_b_clk = (mode_b != CSG_HIZ) & st_reg.sel_now;

    // Enable moves only on falling edges, two stages deep, so the
    // gate opens or closes while the clock is low: no runt pulses
    if (fall)
    begin
      st_next.en_s1    = ref_req;
      st_next.ref_gate = st_reg.en_s1;
    end
    // Copy of selected clock, forced low while gated off
    st_next.ref_out = st_next.ref_gate & st_reg.sel_now;

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_next.aw_got  = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_next.w_got   = 1'b1;
      st_next.w_bit   = s_axi_wdata[`CSG_CTRL_ALLOW];
      st_next.w_lane0 = s_axi_wstrb[0];
    end
    if (st_next.aw_got && st_next.w_got && !st_reg.bvalid)
    begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      if (st_next.aw_addr == `CSG_OFS_CTRL)
      begin
        st_next.bresp = `CSG_RESP_OKAY;
        if (st_next.w_lane0)
          st_next.ref_allow = st_next.w_bit;
      end
      else if (st_next.aw_addr == `CSG_OFS_STATUS)
        st_next.bresp = `CSG_RESP_OKAY;  // Read-only, write ignored
      else
        st_next.bresp = `CSG_RESP_SLVERR;
    end
    else if (st_reg.bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;

    // Read channel: one answer at a time
    if (s_axi_arvalid && s_axi_arready)
    begin
      st_next.rvalid = 1'b1;
      case (s_axi_araddr)
        `CSG_OFS_CTRL:
        begin
          st_next.rdata = {31'h0, st_reg.ref_allow};
          st_next.rresp = `CSG_RESP_OKAY;
        end
        `CSG_OFS_STATUS:
        begin
          st_next.rdata = status;
          st_next.rresp = `CSG_RESP_OKAY;
        end
        default:
        begin
          st_next.rdata = 32'h0;
          st_next.rresp = `CSG_RESP_SLVERR;
        end
      endcase
    end
    else if (st_reg.rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;

    // Synchronous reset
    if (!rstn)
    begin
      st_next           = '0;
      st_next.ref_allow = `CSG_CTRL_RESET;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Handshake readies are combinational from held state
  assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_got && !st_reg.bvalid;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;

  assign crystal_drive_pin = st_reg.xdrv;
  assign osc_power_down    = !st_reg.osc_run;
  assign bank_a_clock      = st_reg.bank_a_clk;
  assign bank_b_clock      = st_reg.bank_b_clk;
  // Straps act directly on the drivers; no register may override them
  assign bank_a_mode       = mode_a;
  assign bank_b_mode       = mode_b;
  assign bank_a_oe         = (mode_a != CSG_HIZ);
  assign bank_b_oe         = (mode_b != CSG_HIZ);
  assign ref_clock_out     = st_reg.ref_out;
  assign ref_clock_oe      = st_reg.ref_gate;

endmodule : csg_top

`default_nettype wire

// ### csg_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Pin-level checks on the clock path
// ----------------------------------------------------------------
module csg_chk
  import csg_pkg::*;
(
  input  wire logic        clock,                 // System clock
  input  wire logic        rstn,                  // Reset, active low
  input  wire logic        primary_clock_input,   // First pair
  input  wire logic        secondary_clock_input, // Second pair
  input  wire logic        crystal_input_pin,     // Crystal pin
  input  wire logic [1:0]  input_source_select,   // Source strap
  input  wire logic [1:0]  bank_a_driver_type,    // Bank A strap
  input  wire logic [1:0]  bank_b_driver_type,    // Bank B strap
  input  wire logic        ref_enable_pin,        // Reference enable
  input  wire logic        crystal_drive_pin,     // Oscillator drive
  input  wire logic        osc_power_down,        // Oscillator off
  input  wire logic        bank_a_clock,          // Bank A clock
  input  wire logic        bank_a_oe,             // Bank A driving
  input  wire csg_drv_type bank_a_mode,           // Bank A type
  input  wire logic        bank_b_oe,             // Bank B driving
  input  wire csg_drv_type bank_b_mode,           // Bank B type
  input  wire logic        ref_clock_out,         // Reference level
  input  wire logic        ref_clock_oe           // Reference driving
);
  logic       mux;   // Selected input right now
  logic       mux_q; // Previous sample, for fall detection
  logic [1:0] sel_q; // Previous strap
  logic [1:0] calm;  // Edges with an unchanged strap, saturating
  logic [2:0] falls; // Falls seen since the enable dropped

  assign mux = input_source_select[1] ? crystal_input_pin :
    (input_source_select[0] ? secondary_clock_input : primary_clock_input);

  // Strap settling and fall counting; a strap change restarts the wait
  always_ff @(posedge clock)
  begin
    sel_q <= input_source_select;
    mux_q <= mux;
    if (!rstn || input_source_select != sel_q) calm <= 2'h0;
    else if (calm != 2'h3) calm <= calm + 2'h1;
    if (!rstn || ref_enable_pin) falls <= 3'h0;
    else if (mux_q && !mux && falls != 3'h7) falls <= falls + 3'h1;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  a_osc_pair_off: assert property (input_source_select != 2'h2 |=> osc_power_down)
    else $error("oscillator powered outside crystal mode");
  a_osc_xtal_on: assert property (input_source_select == 2'h2 |=> !osc_power_down)
    else $error("oscillator off in crystal mode");
  a_xtal_drive: assert property (1'b1 |=> crystal_drive_pin ==
    ($past(input_source_select) == 2'h2 && !$past(crystal_input_pin)))
    else $error("crystal drive wrong");
  a_bank_follow: assert property (calm == 2'h3 && bank_a_driver_type != 2'h3 &&
    $past(bank_a_driver_type) != 2'h3 |-> bank_a_clock == $past(mux, 2))
    else $error("bank clock not the selected input");
  a_bank_types: assert property (bank_a_mode == csg_drv_type'(bank_a_driver_type) &&
    bank_b_mode == csg_drv_type'(bank_b_driver_type) &&
    bank_a_oe == (bank_a_driver_type != 2'h3) && bank_b_oe == (bank_b_driver_type != 2'h3))
    else $error("bank driver type wrong");
  a_ref_off: assert property (falls >= 3'h4 |-> !ref_clock_oe)
    else $error("reference still driven");
  a_ref_closed: assert property (!ref_clock_oe |-> !ref_clock_out)
    else $error("reference toggles while closed");
  a_gate_at_low: assert property ($rose(ref_clock_oe) |-> !ref_clock_out)
    else $error("reference opened on a high level");
  a_ref_copy: assert property (calm == 2'h3 && ref_clock_oe && $past(ref_clock_oe) |->
    ref_clock_out == $past(mux, 2))
    else $error("reference not a copy of the selection");
endmodule : csg_chk

`default_nettype wire

// ### csg_clk_src.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Clock sources: periods 4, 6 and 8 cycles so each pick differs
// ----------------------------------------------------------------
module csg_clk_src
(
  input  wire logic       clock, // Bench clock
  input  wire logic [1:0] hold,  // 0 run, 1 static low or floating, 2 high
  output var  logic       prim,  // First pair
  output var  logic       sec,   // Second pair
  output var  logic       xtal   // Crystal pin
);
  logic [4:0] t = 5'h0; // Phase over the common period of 24

  initial {prim, sec, xtal} = 3'h0;

  // A floating input reads as low through its pull-down
  always @(posedge clock)
  begin
    t <= (t == 5'h17) ? 5'h0 : t + 5'h1;
    prim <= (hold == 2'h0) ? t[1] : hold[1];
    sec <= (hold == 2'h0) ? ((t % 5'h6) < 5'h3) : hold[1];
    xtal <= (hold == 2'h0) ? t[2] : hold[1];
  end
endmodule : csg_clk_src

`default_nettype wire

// ### test_clock_select_and_ref_gate.sv
`timescale 1ns/10ps
`default_nettype none

module test_clock_select_and_ref_gate
  import csg_pkg::*;
;
  logic clock = 1'b0, rstn = 1'b0, ref_enable_pin = 1'b0;
  logic [1:0] input_source_select = 2'h0, bank_a_driver_type = 2'h0, hold = 2'h0;
  logic [1:0] bank_b_driver_type = 2'h3; // Bank B strapped off for the source checks
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic primary_clock_input, secondary_clock_input, crystal_input_pin;
  logic crystal_drive_pin, osc_power_down, bank_a_clock, bank_a_oe, bank_b_clock, bank_b_oe;
  logic ref_clock_out, ref_clock_oe, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  csg_drv_type bank_a_mode, bank_b_mode;
  int mismatches = 0, compares = 0;

  initial forever #25 clock = ~clock;

  csg_top csg_top_i (.*);
  csg_clk_src csg_clk_src_i (.clock(clock), .hold(hold), .prim(primary_clock_input),
    .sec(secondary_clock_input), .xtal(crystal_input_pin));

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp

  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // One AXI4-Lite transfer; for a read, d is the expected data under mask m
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    input logic [31:0] m, input logic [1:0] er);
    logic ta, tw, tr, g;
    logic [31:0] q;
    logic [1:0] r;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    // Wait as long as the slave needs; only the watchdog ends a hang
    do
    begin
      @(negedge clock);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      g = w ? s_axi_bvalid : s_axi_rvalid;
      r = w ? s_axi_bresp : s_axi_rresp;
      q = s_axi_rdata;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
    end while (!g);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    cmp(r, er);
    if (!w) cmp(q & m, d);
  endtask : bus

  // Hang guard, far beyond the few hundred cycles the run needs
  initial
  begin
    #200000;
    mismatches++;
    stop_test;
  end

  initial
  begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    bus(1'b0, 4'h0, 32'h1, 32'hffffffff, 2'h0);
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clock) input_source_select <= s[1:0]; // Straps move only between
      repeat (30) @(posedge clock);
      bus(1'b0, 4'h4, 32'hc0 | 32'(s) | (s == 2 ? 32'h4 : 32'h0), 32'hff, 2'h0);
      cmp(osc_power_down, 32'(s != 2));
    end
    @(posedge clock) input_source_select <= 2'h0;
    for (int t = 0; t < 4; t++)
    begin
      @(posedge clock) bank_a_driver_type <= t[1:0];
      bank_b_driver_type <= 2'h3 - t[1:0];
      repeat (3) @(posedge clock);
      cmp(bank_a_mode, 32'(t));
      cmp(bank_b_oe, 32'(t != 0));
    end
    for (int h = 1; h < 3; h++)
    begin
      @(posedge clock) hold <= h[1:0];
      repeat (6) @(posedge clock);
      cmp(bank_b_clock, 32'(h - 1));
    end
    @(posedge clock) hold <= 2'h0;
    ref_enable_pin <= 1'b1;
    repeat (16) @(posedge clock);
    cmp(ref_clock_oe, 32'h1);
    bus(1'b1, 4'h0, 32'h0, 32'h0, 2'h0);
    repeat (16) @(posedge clock);
    cmp(ref_clock_oe, 32'h0);
    bus(1'b1, 4'h0, 32'h1, 32'h0, 2'h0);
    repeat (16) @(posedge clock);
    cmp(ref_clock_oe, 32'h1);
    @(posedge clock) ref_enable_pin <= 1'b0;
    repeat (40) @(posedge clock);
    cmp(ref_clock_oe, 32'h0);
    bus(1'b0, 4'h8, 32'h0, 32'hffffffff, 2'h2);
    bus(1'b1, 4'h8, 32'h5, 32'h0, 2'h2);
    bus(1'b1, 4'h4, 32'h0, 32'h0, 2'h0);
    // Clear the permission so the read after reset proves its reset value
    bus(1'b1, 4'h0, 32'h0, 32'h0, 2'h0);
    bus(1'b0, 4'h0, 32'h0, 32'hffffffff, 2'h0);
    @(posedge clock) rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    bus(1'b0, 4'h0, 32'h1, 32'hffffffff, 2'h0);
    stop_test;
  end
endmodule : test_clock_select_and_ref_gate

bind csg_top csg_chk csg_chk_i (.*);

`default_nettype wire
